// File: burner_status_defs.svh
// Offsets, widths and timing counts for the burner discrete status bank.
`ifndef BURNER_STATUS_DEFS_SVH
`define BURNER_STATUS_DEFS_SVH
// ==========================================================================
// Bit offsets of the discrete inputs.
`define OFF_LEVEL_CONTACT 6'h10
`define OFF_MAIN_VALVE_FB 6'h11
`define OFF_PILOT_VALVE_FB 6'h12
`define OFF_HIGH_PRESSURE 6'h13
`define OFF_CLOSURE_PROOF 6'h14
`define OFF_EMERGENCY_SHUTDOWN 6'h15
`define OFF_REMOTE_START 6'h16
`define OFF_LOW_PRESSURE 6'h17
`define OFF_FLAME_PRESENT 6'h18
`define OFF_FLAME_TEST_FAIL 6'h19
`define OFF_UNIT_FAIL 6'h1a
`define OFF_SUPPLY_FAULT 6'h1b
`define OFF_OVER_TEMPERATURE 6'h1c
`define OFF_LOOP_ALARM 6'h1d
`define OFF_LEVEL_LATCHED 6'h20
// ==========================================================================
// Widths.
`define ADDR_W 6
`define LOOP_ALARM_W 16
`define BYTE_W 8
`define BIT_IDX_W 3
// ==========================================================================
// Flame self-test period: 1.2 s at a 10 ns clock.
`define FLAME_TEST_PERIOD_MS 1200
`define CLK_PERIOD_NS 10
`define FLAME_TEST_CYCLES ((`FLAME_TEST_PERIOD_MS * 1000000) / `CLK_PERIOD_NS)
`define CNT_W 27
`endif

// File: burner_status_pkg.sv
// Types shared by the burner discrete status bank.
package burner_status_pkg;
  // ==========================================================================
  // Read engine states.
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_PACK = 2'b01,
    ST_DONE = 2'b10
  } read_state_t;
endpackage : burner_status_pkg

// File: burner_discrete_status_bits.sv
// Discrete status bit bank with bit-packed multi-bit read port.
`timescale 1ns/10ps
`include "burner_status_defs.svh"
module burner_discrete_status_bits
  import burner_status_pkg::*;
#(
  parameter int FLAME_TEST_CYCLES = `FLAME_TEST_CYCLES
)
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic level_contact_open,
  input wire logic low_fire_output_voltage,
  input wire logic high_fire_output_voltage,
  input wire logic pilot_output_voltage,
  input wire logic high_pressure_contact_open,
  input wire logic closure_proof_contact_open,
  input wire logic emergency_shutdown_contact_open,
  input wire logic remote_start_contact_open,
  input wire logic low_pressure_contact_open,
  input wire logic flame_sufficient,
  input wire logic flame_test_result_valid,
  input wire logic flame_test_result_pass,
  input wire logic unit_selftests_ok,
  input wire logic supply_voltage_in_limits,
  input wire logic over_temperature_exceeded,
  input wire logic [`LOOP_ALARM_W-1:0] loop_alarm_word,
  input wire logic system_running,
  input wire logic read_req,
  input wire logic [`ADDR_W-1:0] read_start,
  input wire logic [`ADDR_W:0] read_count,
  output logic flame_test_start,
  output logic read_byte_valid,
  output logic [`BYTE_W-1:0] read_byte,
  output logic read_byte_last,
  output logic read_busy
);

  // ==========================================================================
  // Status registers.
  logic [63:0] status_reg; // Bit vector indexed by offset.
  logic level_latched_reg; // Sticky copy of the level contact.
  logic flame_fail_reg; // Result of the last flame self-test.
  logic running_d_reg; // Previous run level, to spot a restart.
  logic [`CNT_W-1:0] test_cnt_reg; // Flame self-test period counter.

  // Returns one status bit, zero for unmapped offsets.
  function automatic logic pick_bit(input logic [63:0] v, input logic [`ADDR_W:0] a);
    pick_bit = a[`ADDR_W] ? 1'b0 : v[a[`ADDR_W-1:0]];
  endfunction : pick_bit

  // Assembles the live bit map from the inputs.
  always_comb
  begin
    status_reg = 64'h0;
    status_reg[`OFF_LEVEL_CONTACT] = level_contact_open;
    status_reg[`OFF_MAIN_VALVE_FB] = low_fire_output_voltage | high_fire_output_voltage;
    status_reg[`OFF_PILOT_VALVE_FB] = pilot_output_voltage;
    status_reg[`OFF_HIGH_PRESSURE] = high_pressure_contact_open;
    status_reg[`OFF_CLOSURE_PROOF] = closure_proof_contact_open;
    status_reg[`OFF_EMERGENCY_SHUTDOWN] = emergency_shutdown_contact_open;
    status_reg[`OFF_REMOTE_START] = remote_start_contact_open;
    status_reg[`OFF_LOW_PRESSURE] = low_pressure_contact_open;
    status_reg[`OFF_FLAME_PRESENT] = flame_sufficient;
    status_reg[`OFF_FLAME_TEST_FAIL] = flame_fail_reg;
    status_reg[`OFF_UNIT_FAIL] = ~unit_selftests_ok;
    status_reg[`OFF_SUPPLY_FAULT] = ~supply_voltage_in_limits;
    status_reg[`OFF_OVER_TEMPERATURE] = over_temperature_exceeded;
    status_reg[`OFF_LOOP_ALARM] = |loop_alarm_word;
    status_reg[`OFF_LEVEL_LATCHED] = level_latched_reg;
  end

  // ==========================================================================
  // Flame self-test timer: pulses a test start once per period.
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      test_cnt_reg <= '0;
      flame_test_start <= 1'b0;
    end
    else if (test_cnt_reg == `CNT_W'(FLAME_TEST_CYCLES - 1))
    begin
      test_cnt_reg <= '0;
      flame_test_start <= 1'b1;
    end
    else
    begin
      test_cnt_reg <= test_cnt_reg + `CNT_W'(1);
      flame_test_start <= 1'b0;
    end
  end

  // Captures the pass or fail outcome of each flame self-test.
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      flame_fail_reg <= 1'b0;
    else if (flame_test_result_valid)
      flame_fail_reg <= ~flame_test_result_pass;
  end

  // ==========================================================================
  // Latched level copy: set wins; cleared only on a stop-to-run restart.
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      level_latched_reg <= 1'b0;
      running_d_reg <= 1'b0;
    end
    else
    begin
      running_d_reg <= system_running;
      if (level_contact_open)
        level_latched_reg <= 1'b1;
      else if (system_running && !running_d_reg)
        level_latched_reg <= 1'b0;
    end
  end

  // ==========================================================================
  // Read engine: packs bits LSB first into bytes; reads touch no status.
  read_state_t state_reg; // Engine state.
  logic [`ADDR_W:0] addr_reg; // Next offset to pack.
  logic [`ADDR_W:0] left_reg; // Bits still to pack.
  logic [`BIT_IDX_W-1:0] bit_reg; // Bit position in the current byte.
  logic [`BYTE_W-1:0] acc_reg; // Byte being assembled.

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg <= ST_IDLE;
      addr_reg <= '0;
      left_reg <= '0;
      bit_reg <= '0;
      acc_reg <= '0;
      read_byte_valid <= 1'b0;
      read_byte <= '0;
      read_byte_last <= 1'b0;
      read_busy <= 1'b0;
    end
    else
    begin
      read_byte_valid <= 1'b0;
      read_byte_last <= 1'b0;
      case (state_reg)
        ST_IDLE:
        begin
          if (read_req && read_count != '0)
          begin
            addr_reg <= {1'b0, read_start};
            left_reg <= read_count;
            bit_reg <= '0;
            acc_reg <= '0;
            read_busy <= 1'b1;
            state_reg <= ST_PACK;
          end
        end
        ST_PACK:
        begin
          // Unused high bits stay zero because the byte starts cleared.
          if (bit_reg == `BIT_IDX_W'(`BYTE_W - 1) || left_reg == 7'h01)
          begin
            read_byte <= acc_reg | (`BYTE_W'(pick_bit(status_reg, addr_reg)) << bit_reg);
            read_byte_valid <= 1'b1;
            acc_reg <= '0;
            if (left_reg == 7'h01)
            begin
              read_byte_last <= 1'b1;
              state_reg <= ST_DONE;
            end
          end
          else
            acc_reg <= acc_reg | (`BYTE_W'(pick_bit(status_reg, addr_reg)) << bit_reg);
          bit_reg <= bit_reg + `BIT_IDX_W'(1);
          addr_reg <= addr_reg + 7'h01;
          left_reg <= left_reg - 7'h01;
        end
        ST_DONE:
        begin
          read_busy <= 1'b0;
          state_reg <= ST_IDLE;
        end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Checks.
  // Restart strobe exactly as the latch process decodes it.
  sequence s_restart;
    system_running && !running_d_reg;
  endsequence

  // A request that the read engine accepts.
  sequence s_take;
    read_req && !read_busy && read_count != 7'h00;
  endsequence

  // A one-bit request aimed at a chosen offset.
  sequence s_single_at(logic [`ADDR_W-1:0] off);
    read_req && !read_busy && read_count == 7'h01 && read_start == off;
  endsequence

  // A set latched bit survives every cycle that is not a restart.
  property p_latch_holds;
    @(posedge core_clk) disable iff (!resetn)
    (level_latched_reg && !(system_running && !running_d_reg)) |=> level_latched_reg;
  endproperty
  a_latch_holds: assert property (p_latch_holds) else $error("latched level bit dropped");

  // An open contact sets the latched copy on the next edge, restart or not.
  property p_latch_sets;
    @(posedge core_clk) disable iff (!resetn)
    level_contact_open |=> level_latched_reg;
  endproperty
  a_latch_sets: assert property (p_latch_sets) else $error("latched level bit not set");

  // The self-test start is a single-cycle pulse.
  property p_test_period;
    @(posedge core_clk) disable iff (!resetn)
    flame_test_start |=> !flame_test_start;
  endproperty
  a_test_period: assert property (p_test_period) else $error("flame test pulses too close");

  // The fail bit follows the result that came with the strobe.
  property p_fail_capture;
    @(posedge core_clk) disable iff (!resetn)
    flame_test_result_valid |=> (flame_fail_reg == !$past(flame_test_result_pass));
  endproperty
  a_fail_capture: assert property (p_fail_capture) else $error("flame fail not captured");

  // A single read of the main feedback bit carries the voltage seen on either fire output.
  property p_main_fb;
    @(posedge core_clk) disable iff (!resetn)
    s_single_at(`OFF_MAIN_VALVE_FB) |=> ##1
      (read_byte[0] == $past(low_fire_output_voltage | high_fire_output_voltage));
  endproperty
  a_main_fb: assert property (p_main_fb) else $error("main feedback wrong");

  // A single read of the loop summary carries the OR of the whole alarm word.
  property p_loop_or;
    @(posedge core_clk) disable iff (!resetn)
    s_single_at(`OFF_LOOP_ALARM) |=> ##1
      (read_byte[0] == $past(loop_alarm_word != '0));
  endproperty
  a_loop_or: assert property (p_loop_or) else $error("loop alarm summary wrong");

  // A single-bit read returns one byte with its high bits cleared.
  sequence s_single_read;
    read_req && !read_busy && read_count == 7'h01;
  endsequence
  property p_single_byte;
    @(posedge core_clk) disable iff (!resetn)
    s_single_read |=> ##1 (read_byte_valid && read_byte_last && read_byte[7:1] == 7'h00);
  endproperty
  a_single_byte: assert property (p_single_byte) else $error("single read not one padded byte");

  // The last byte closes the read and frees the engine one edge later.
  property p_last_ends;
    @(posedge core_clk) disable iff (!resetn)
    read_byte_last |-> read_byte_valid ##1 (!read_busy && state_reg == ST_IDLE);
  endproperty
  a_last_ends: assert property (p_last_ends) else $error("read did not finish");

  // A restart with the contact closed clears the latched copy.
  property p_restart_clears;
    @(posedge core_clk) disable iff (!resetn)
    (s_restart ##0 !level_contact_open) |=> !level_latched_reg;
  endproperty
  a_restart_clears: assert property (p_restart_clears) else $error("latched level bit not cleared");

  // An accepted request raises busy on the next edge.
  property p_take_busy;
    @(posedge core_clk) disable iff (!resetn)
    s_take |=> read_busy;
  endproperty
  a_take_busy: assert property (p_take_busy) else $error("read not started");

  // While a read runs with no set, restart or test result, status does not move.
  property p_read_no_side;
    @(posedge core_clk) disable iff (!resetn)
    (read_busy && !level_contact_open && !(system_running && !running_d_reg) && !flame_test_result_valid)
      |=> ($stable(level_latched_reg) && $stable(flame_fail_reg));
  endproperty
  a_read_no_side: assert property (p_read_no_side) else $error("read changed a status bit");

endmodule : burner_discrete_status_bits

// File: modbus_master_model.sv
// Behavioural serial master that issues discrete-input reads and gathers bytes.
`timescale 1ns/10ps
module modbus_master_model (
  input wire logic core_clk,
  input wire logic read_busy,
  input wire logic read_byte_valid,
  input wire logic [7:0] read_byte,
  input wire logic read_byte_last,
  output logic read_req,
  output logic [5:0] read_start,
  output logic [6:0] read_count
);
  // ==========================================================================
  // Request lines idle low from time zero.
  initial
  begin
    read_req = 1'b0;
    read_start = 6'h00;
    read_count = 7'h00;
  end
  // One read-input-status request, bytes collected LSB byte first.
  task automatic read_bits(input logic [5:0] s, input logic [6:0] n, output logic [15:0] r);
    int k;
    int idx;
    r = 16'h0000;
    idx = 0;
    @(negedge core_clk);
    for (k = 0; k < 40 && read_busy !== 1'b0; k++)
      @(negedge core_clk);
    read_req = 1'b1;
    read_start = s;
    read_count = n;
    @(negedge core_clk);
    // Released lines show the inverse so stale values are not trusted.
    read_req = 1'b0;
    read_start = ~s;
    read_count = ~n;
    for (k = 0; k < 40 && idx < 2; k++)
    begin
      @(posedge core_clk);
      #1;
      if (read_byte_valid === 1'b1)
      begin
        r[idx*8+:8] = read_byte;
        idx++;
        if (read_byte_last === 1'b1)
          break;
      end
    end
  endtask : read_bits
endmodule : modbus_master_model

// File: testbench.sv
// Self-checking testbench for the burner discrete status bank.
`timescale 1ns/10ps
module testbench;
  localparam int FT_CYCLES = 20;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [13:0] cond = 14'h0000;
  logic hf_sel = 1'b0;
  logic system_running = 1'b1;
  logic ft_valid = 1'b0;
  logic ft_pass = 1'b0;
  logic read_req, read_byte_valid, read_byte_last, read_busy, flame_test_start;
  logic [5:0] read_start;
  logic [6:0] read_count;
  logic [7:0] read_byte;
  int fails = 0;
  int n_tests = 0;
  int cycles = 0;
  // ==========================================================================
  // Clock, hang limit and instances.
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fails++;
      finish_test();
    end
  end
  burner_discrete_status_bits #(.FLAME_TEST_CYCLES(FT_CYCLES)) i_burner_discrete_status_bits (
    .core_clk(core_clk),
    .resetn(resetn),
    .level_contact_open(cond[0]),
    .low_fire_output_voltage(cond[1] & ~hf_sel),
    .high_fire_output_voltage(cond[1] & hf_sel),
    .pilot_output_voltage(cond[2]),
    .high_pressure_contact_open(cond[3]),
    .closure_proof_contact_open(cond[4]),
    .emergency_shutdown_contact_open(cond[5]),
    .remote_start_contact_open(cond[6]),
    .low_pressure_contact_open(cond[7]),
    .flame_sufficient(cond[8]),
    .flame_test_result_valid(ft_valid),
    .flame_test_result_pass(ft_pass),
    .unit_selftests_ok(~cond[10]),
    .supply_voltage_in_limits(~cond[11]),
    .over_temperature_exceeded(cond[12]),
    .loop_alarm_word({cond[13] & hf_sel, 14'h0000, cond[13] & ~hf_sel}),
    .system_running(system_running),
    .read_req(read_req),
    .read_start(read_start),
    .read_count(read_count),
    .flame_test_start(flame_test_start),
    .read_byte_valid(read_byte_valid),
    .read_byte(read_byte),
    .read_byte_last(read_byte_last),
    .read_busy(read_busy)
  );
  modbus_master_model i_master (
    .core_clk(core_clk),
    .read_busy(read_busy),
    .read_byte_valid(read_byte_valid),
    .read_byte(read_byte),
    .read_byte_last(read_byte_last),
    .read_req(read_req),
    .read_start(read_start),
    .read_count(read_count)
  );
  // ==========================================================================
  // Compare and read helpers.
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic rd(input string name, input logic [5:0] s, input logic [6:0] n, input logic [15:0] exp);
    logic [15:0] r;
    i_master.read_bits(s, n, r);
    check(name, exp, r);
  endtask : rd
  // ==========================================================================
  // Scenarios.
  task automatic test_bit_map();
    @(negedge core_clk);
    cond = 14'h3555;
    rd("bank a", 6'h10, 7'd14, 16'h3555);
    @(negedge core_clk);
    cond = 14'h28aa;
    hf_sel = 1'b1;
    rd("bank b", 6'h10, 7'd14, 16'h28aa);
    rd("main single", 6'h11, 7'd1, 16'h0001);
    rd("loop single", 6'h1d, 7'd1, 16'h0001);
    rd("unmapped", 6'h1e, 7'd2, 16'h0000);
    $display("bit map test done");
  endtask : test_bit_map
  task automatic test_flame();
    int k;
    int gap;
    for (k = 0; k < 100 && flame_test_start !== 1'b1; k++)
      @(posedge core_clk) #1;
    gap = 0;
    do
    begin
      @(posedge core_clk) #1;
      gap++;
    end
    while (flame_test_start !== 1'b1 && gap < 100);
    check("test period", 16'(FT_CYCLES), 16'(gap));
    for (k = 0; k < 2; k++)
    begin
      @(negedge core_clk);
      ft_valid = 1'b1;
      ft_pass = k[0];
      @(negedge core_clk);
      ft_valid = 1'b0;
      rd("flame fail", 6'h19, 7'd1, {15'h0000, ~k[0]});
    end
    $display("flame test done");
  endtask : test_flame
  task automatic test_latch();
    @(negedge core_clk);
    system_running = 1'b0;
    repeat (2) @(negedge core_clk);
    system_running = 1'b1;
    rd("latch cleared", 6'h20, 7'd1, 16'h0000);
    @(negedge core_clk);
    cond = 14'h0001;
    system_running = 1'b0;
    repeat (2) @(negedge core_clk);
    system_running = 1'b1;
    @(negedge core_clk);
    cond = 14'h0000;
    rd("latched", 6'h20, 7'd1, 16'h0001);
    rd("latched reread", 6'h20, 7'd1, 16'h0001);
    rd("live level", 6'h10, 7'd1, 16'h0000);
    @(negedge core_clk);
    system_running = 1'b0;
    repeat (2) @(negedge core_clk);
    system_running = 1'b1;
    rd("after restart", 6'h20, 7'd1, 16'h0000);
    $display("latch test done");
  endtask : test_latch
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  // Reset for 12 cycles, then run every scenario.
  initial
  begin
    repeat (12) @(negedge core_clk);
    resetn = 1'b1;
    test_bit_map();
    test_flame();
    test_latch();
    finish_test();
  end
endmodule : testbench
